//--- hw/dasc_top.v
// two-channel converter source selection, result registers and trim current control
// Function
// - one 10-bit converter per channel, running only in controller mode.
// - source code with top bit zero disables that channel's converter.
// - channel 1 codes 101/110/111 pick main supply, supply line, laser anode.
// - channel 2 code 101 picks logic supply; 110/111 its line and anode.
// - code 100 without current measure: force/sense bit picks resistor node or cathode.
// - current measure with code 100 routes mirrored laser current; software sets 100.
// - enabled converter samples back to back without any trigger.
// - every conversion takes 140 microseconds before the result appears.
// - no end flag in the registers, only a one-cycle done pulse per channel port; result always holds last conversion; reading starts nothing.
// - 6-bit trim code sets trim pin current, zero none, 0x3F maximum.
// - each trim code step adds 2 microamps.
// - in standalone mode converters stop and registers are unreachable.
`timescale 1ns/1ps
`default_nettype none
`include "dasc_regs.vh"

module dasc_top #(
    parameter [14:0] CONV_CYCLES = `DASC_CONV_CYCLES
) (
    input wire sys_clk_in,
    input wire rst_in,
    input wire controller_mode_pin_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [9:0] ch1_sample_in,
    input wire [9:0] ch2_sample_in,
    output reg [7:0] reg_rdata_out,
    output reg mcu_mode_out,
    output wire [2:0] ch1_route_out,
    output wire [2:0] ch2_route_out,
    output wire ch1_conv_done_out,
    output wire ch2_conv_done_out,
    output reg [5:0] trim_current_code_out,
    output reg [6:0] trim_current_ua_out
);

    // pin and analog inputs come from outside the clock domain
    reg mode_sync1;
    reg mode_sync2;
    reg [9:0] ch1_sample_sync1;
    reg [9:0] ch1_sample_sync2;
    reg [9:0] ch2_sample_sync1;
    reg [9:0] ch2_sample_sync2;

    reg [2:0] ch1_source;
    reg [2:0] ch2_source;
    reg ch1_current_measure;
    reg ch2_current_measure;
    reg ch1_force_sense;
    reg ch2_force_sense;
    reg [5:0] trim_code;

    wire [9:0] ch1_result;
    wire [9:0] ch2_result;
    wire reg_wr_ok;
    wire reg_rd_ok;
    reg [7:0] next_rdata;

    // the analog side holds its code steady through a conversion, so a bus
    // that settles in the two sync stages is captured whole at the end
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            mode_sync1 <= 1'b0;
            mode_sync2 <= 1'b0;
            ch1_sample_sync1 <= 10'h000;
            ch1_sample_sync2 <= 10'h000;
            ch2_sample_sync1 <= 10'h000;
            ch2_sample_sync2 <= 10'h000;
        end else begin
            mode_sync1 <= controller_mode_pin_in;
            mode_sync2 <= mode_sync1;
            ch1_sample_sync1 <= ch1_sample_in;
            ch1_sample_sync2 <= ch1_sample_sync1;
            ch2_sample_sync1 <= ch2_sample_in;
            ch2_sample_sync2 <= ch2_sample_sync1;
        end
    end

    // standalone mode disables the serial side entirely
    assign reg_wr_ok = reg_wr_in & mode_sync2;
    assign reg_rd_ok = reg_rd_in & mode_sync2;

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            ch1_source <= `DASC_SRC_RESET;
            ch2_source <= `DASC_SRC_RESET;
            ch1_current_measure <= `DASC_CMES_RESET;
            ch2_current_measure <= `DASC_CMES_RESET;
            ch1_force_sense <= `DASC_FS_RESET;
            ch2_force_sense <= `DASC_FS_RESET;
            trim_code <= `DASC_TRIM_RESET;
        end else if (reg_wr_ok) begin
            // result addresses fall through and are not written
            if (reg_addr_in == `DASC_ADDR_CH1_CTRL) begin
                ch1_source <= reg_wdata_in[`DASC_SRC_MSB:`DASC_SRC_LSB];
                ch1_current_measure <= reg_wdata_in[`DASC_CMES_BIT];
            end else if (reg_addr_in == `DASC_ADDR_CH2_CTRL) begin
                ch2_source <= reg_wdata_in[`DASC_SRC_MSB:`DASC_SRC_LSB];
                ch2_current_measure <= reg_wdata_in[`DASC_CMES_BIT];
            end else if (reg_addr_in == `DASC_ADDR_FORCE_SENSE) begin
                ch1_force_sense <= reg_wdata_in[`DASC_FS1_BIT];
                ch2_force_sense <= reg_wdata_in[`DASC_FS2_BIT];
            end else if (reg_addr_in == `DASC_ADDR_TRIM) begin
                trim_code <= reg_wdata_in[`DASC_TRIM_MSB:0];
            end
        end
    end

    always @* begin
        next_rdata = 8'h00;
        if (reg_addr_in == `DASC_ADDR_CH1_RESULT_UPPER) begin
            next_rdata = {6'h00, ch1_result[9:8]};
        end else if (reg_addr_in == `DASC_ADDR_CH1_RESULT_LOWER) begin
            next_rdata = ch1_result[7:0];
        end else if (reg_addr_in == `DASC_ADDR_CH2_RESULT_UPPER) begin
            next_rdata = {6'h00, ch2_result[9:8]};
        end else if (reg_addr_in == `DASC_ADDR_CH2_RESULT_LOWER) begin
            next_rdata = ch2_result[7:0];
        end else if (reg_addr_in == `DASC_ADDR_CH1_CTRL) begin
            next_rdata = {ch1_source, 1'b0, ch1_current_measure, 3'h0};
        end else if (reg_addr_in == `DASC_ADDR_CH2_CTRL) begin
            next_rdata = {ch2_source, 1'b0, ch2_current_measure, 3'h0};
        end else if (reg_addr_in == `DASC_ADDR_FORCE_SENSE) begin
            next_rdata = {1'b0, ch2_force_sense, 3'h0, ch1_force_sense, 2'h0};
        end else if (reg_addr_in == `DASC_ADDR_TRIM) begin
            next_rdata = {2'h0, trim_code};
        end
    end

    // a read only copies the value; it has no side effect on the converters
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
            mcu_mode_out <= 1'b0;
            trim_current_code_out <= `DASC_TRIM_RESET;
            trim_current_ua_out <= 7'h00;
        end else begin
            if (reg_rd_ok) begin
                reg_rdata_out <= next_rdata;
            end
            mcu_mode_out <= mode_sync2;
            trim_current_code_out <= trim_code;
            // current in microamps, 2 per step, 126 at full code
            trim_current_ua_out <= {trim_code, 1'b0};
        end
    end

    dasc_adc_chan #(
        .CONV_CYCLES(CONV_CYCLES)
    ) u_ch1 (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .enable_in(mode_sync2),
        .adc_source_select_in(ch1_source),
        .force_sense_select_in(ch1_force_sense),
        .current_measure_select_in(ch1_current_measure),
        .sample_in(ch1_sample_sync2),
        .route_out(ch1_route_out),
        .conversion_result_out(ch1_result),
        .done_out(ch1_conv_done_out)
    );

    dasc_adc_chan #(
        .CONV_CYCLES(CONV_CYCLES)
    ) u_ch2 (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .enable_in(mode_sync2),
        .adc_source_select_in(ch2_source),
        .force_sense_select_in(ch2_force_sense),
        .current_measure_select_in(ch2_current_measure),
        .sample_in(ch2_sample_sync2),
        .route_out(ch2_route_out),
        .conversion_result_out(ch2_result),
        .done_out(ch2_conv_done_out)
    );

endmodule // dasc_top
`default_nettype wire

//--- pkg/dasc_regs.vh
// register map, field positions, reset values and timing for the converter and trim control
`ifndef DASC_REGS_VH
`define DASC_REGS_VH

// register byte addresses
`define DASC_ADDR_CH1_RESULT_UPPER 8'h03
`define DASC_ADDR_CH1_RESULT_LOWER 8'h04
`define DASC_ADDR_CH2_RESULT_UPPER 8'h05
`define DASC_ADDR_CH2_RESULT_LOWER 8'h06
`define DASC_ADDR_CH1_CTRL 8'h10
`define DASC_ADDR_CH2_CTRL 8'h15
`define DASC_ADDR_FORCE_SENSE 8'h1A
`define DASC_ADDR_TRIM 8'h1B

// field positions
`define DASC_SRC_MSB 7
`define DASC_SRC_LSB 5
`define DASC_CMES_BIT 3
`define DASC_FS1_BIT 2
`define DASC_FS2_BIT 6
`define DASC_TRIM_MSB 5

// reset values
`define DASC_SRC_RESET 3'h0
`define DASC_FS_RESET 1'h0
`define DASC_CMES_RESET 1'h0
`define DASC_TRIM_RESET 6'h02

// source-select codes
`define DASC_SRC_MONITOR 3'h4
`define DASC_SRC_SUPPLY 3'h5
`define DASC_SRC_LINE 3'h6
`define DASC_SRC_ANODE 3'h7

// routing codes driven to the analog input multiplexer
`define DASC_ROUTE_OFF 3'h0
`define DASC_ROUTE_MONITOR_RES 3'h1
`define DASC_ROUTE_CATHODE 3'h2
`define DASC_ROUTE_CURRENT 3'h3
`define DASC_ROUTE_SUPPLY 3'h4
`define DASC_ROUTE_LINE 3'h5
`define DASC_ROUTE_ANODE 3'h6

// timing
`define DASC_CLK_MHZ 200
`define DASC_CONV_TIME_US 140
// 140 us at 200 MHz, 28000 cycles, which fits within the 15-bit conversion counter
`define DASC_CONV_CYCLES 15'h6D60

// trim current step in microamps
`define DASC_TRIM_STEP_UA 2

`endif

//--- hw/dasc_adc_chan.v
// one converter channel: input routing and free-running conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "dasc_regs.vh"

module dasc_adc_chan #(
    parameter [14:0] CONV_CYCLES = `DASC_CONV_CYCLES
) (
    input wire sys_clk_in,
    input wire rst_in,
    input wire enable_in,
    input wire [2:0] adc_source_select_in,
    input wire force_sense_select_in,
    input wire current_measure_select_in,
    input wire [9:0] sample_in,
    output reg [2:0] route_out,
    output reg [9:0] conversion_result_out,
    output reg done_out
);

    reg [14:0] conv_cnt;
    reg [2:0] next_route;

    always @* begin
        next_route = `DASC_ROUTE_OFF;
        if (enable_in) begin
            case (adc_source_select_in)
                `DASC_SRC_MONITOR: begin
                    if (current_measure_select_in) begin
                        next_route = `DASC_ROUTE_CURRENT;
                    end else if (force_sense_select_in) begin
                        next_route = `DASC_ROUTE_CATHODE;
                    end else begin
                        next_route = `DASC_ROUTE_MONITOR_RES;
                    end
                end
                `DASC_SRC_SUPPLY: next_route = `DASC_ROUTE_SUPPLY;
                `DASC_SRC_LINE: next_route = `DASC_ROUTE_LINE;
                `DASC_SRC_ANODE: next_route = `DASC_ROUTE_ANODE;
                default: next_route = `DASC_ROUTE_OFF;
            endcase
        end
    end

    // a route change restarts the count so no result mixes two inputs
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            conv_cnt <= 15'h0000;
            route_out <= `DASC_ROUTE_OFF;
            conversion_result_out <= 10'h000;
            done_out <= 1'b0;
        end else begin
            route_out <= next_route;
            done_out <= 1'b0;
            if (next_route == `DASC_ROUTE_OFF || next_route != route_out) begin
                conv_cnt <= 15'h0000;
            end else if (conv_cnt == CONV_CYCLES - 15'h0001) begin
                conv_cnt <= 15'h0000;
                conversion_result_out <= sample_in;
                done_out <= 1'b1;
            end else begin
                conv_cnt <= conv_cnt + 15'h0001;
            end
        end
    end

endmodule // dasc_adc_chan
`default_nettype wire

//--- verif/dasc_top_assertions.sv
// concurrent checks on the converter and trim control ports
`timescale 1ns/1ps
`default_nettype none
module dasc_chk #(parameter [14:0] CONV_CYCLES = 15'h0010) (
    input wire sys_clk_in,
    input wire rst_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_rdata_out,
    input wire mcu_mode_out,
    input wire [2:0] ch1_route_out,
    input wire [2:0] ch2_route_out,
    input wire ch1_conv_done_out,
    input wire [5:0] trim_current_code_out,
    input wire [6:0] trim_current_ua_out
);
    reg [2:0] last_route;
    reg [15:0] gap;
    reg timed;
    // period is only judged between two results with no route change in between
    always @(posedge sys_clk_in) begin
        last_route <= ch1_route_out;
        gap <= ch1_conv_done_out ? 16'h0000 : gap + 16'h0001;
        if (rst_in || ch1_route_out != last_route) timed <= 1'b0;
        else if (ch1_conv_done_out) timed <= 1'b1;
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_taken(a);
        reg_addr_in == a && mcu_mode_out && $past(mcu_mode_out);
    endsequence
    a_done_period: assert property (ch1_conv_done_out && timed &&
        ch1_route_out == last_route |-> gap == CONV_CYCLES - 1) else $error("bad period");
    a_done_on_time: assert property (timed && ch1_route_out != 3'h0
        |-> gap < CONV_CYCLES) else $error("conversion result missing");
    a_done_one_cycle: assert property (ch1_conv_done_out |=> !ch1_conv_done_out)
        else $error("done longer than a cycle");
    a_no_done_off: assert property (ch1_route_out == 3'h0 &&
        $past(ch1_route_out) == 3'h0 |-> !ch1_conv_done_out) else $error("done while off");
    a_route_standalone: assert property (!mcu_mode_out && !$past(mcu_mode_out)
        |-> ch1_route_out == 3'h0 && ch2_route_out == 3'h0) else $error("route in standalone");
    a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data changed without read");
    a_upper_byte: assert property (reg_rd_in and s_taken(8'h03)
        |=> reg_rdata_out[7:2] == 6'h00) else $error("upper byte high bits set");
    // the trim output is one register behind the trim code, so it shows two edges on
    a_trim_write: assert property (reg_wr_in and s_taken(8'h1B) |=> ##1
        {2'b00, trim_current_code_out} == ($past(reg_wdata_in, 2) & 8'h3F)) else $error("trim");
    a_trim_current: assert property ($stable(trim_current_code_out) && !$past(rst_in) &&
        !$past(rst_in, 2) |-> trim_current_ua_out == {trim_current_code_out, 1'b0})
        else $error("trim current not two per step");
endmodule // dasc_chk
bind dasc_top dasc_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .mcu_mode_out(mcu_mode_out), .ch1_route_out(ch1_route_out), .ch2_route_out(ch2_route_out),
    .ch1_conv_done_out(ch1_conv_done_out), .trim_current_code_out(trim_current_code_out),
    .trim_current_ua_out(trim_current_ua_out));
`default_nettype wire

//--- verif/dasc_host_model.sv
// host controller model: one-cycle register strobes launched on falling edges
`timescale 1ns/1ps
`default_nettype none
module dasc_host_model (
    input wire logic sys_clk_in,
    input wire logic [7:0] host_rdata_in,
    output logic [7:0] host_addr_out,
    output logic [7:0] host_wdata_out,
    output logic host_wr_out,
    output logic host_rd_out
);
    initial begin
        host_addr_out = 8'h00;
        host_wdata_out = 8'h00;
        host_wr_out = 1'b0;
        host_rd_out = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_in);
        host_addr_out = a;
        host_wdata_out = d;
        host_wr_out = 1'b1;
        @(negedge sys_clk_in);
        host_wr_out = 1'b0;
        // released lines flip so a stale address can never pass as valid
        host_addr_out = ~a;
        host_wdata_out = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk_in);
        host_addr_out = a;
        host_rd_out = 1'b1;
        @(negedge sys_clk_in);
        host_rd_out = 1'b0;
        host_addr_out = ~a;
        d = host_rdata_in;
    endtask
    task automatic rd_result(input logic [7:0] a, output logic [9:0] v);
        logic [7:0] hi;
        logic [7:0] lo;
        rd(a, hi);
        rd(a + 8'h01, lo);
        v = {hi[1:0], lo};
    endtask
endmodule // dasc_host_model
`default_nettype wire

//--- verif/dasc_top_test.sv
// self-checking bench for converter source selection, results and trim current
`timescale 1ns/1ps
`default_nettype none
module dasc_top_test;
    localparam [14:0] CONV = 15'h0010;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic mode_pin = 1'b1;
    logic [9:0] ch1_sample = 10'h000, ch2_sample = 10'h000, v;
    logic [7:0] addr, wdata, rdata, got;
    logic wr, rd, d1, d2, mode;
    logic [2:0] r1, r2;
    logic [5:0] tcode;
    logic [6:0] tua;
    int failures = 0, checks_done = 0, n;
    always #2.5 sys_clk_in = ~sys_clk_in;
    dasc_host_model host (.sys_clk_in(sys_clk_in), .host_rdata_in(rdata), .host_addr_out(addr),
        .host_wdata_out(wdata), .host_wr_out(wr), .host_rd_out(rd));
    dasc_top #(.CONV_CYCLES(CONV)) uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .controller_mode_pin_in(mode_pin), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .ch1_sample_in(ch1_sample), .ch2_sample_in(ch2_sample),
        .reg_rdata_out(rdata), .mcu_mode_out(mode), .ch1_route_out(r1), .ch2_route_out(r2),
        .ch1_conv_done_out(d1), .ch2_conv_done_out(d2), .trim_current_code_out(tcode),
        .trim_current_ua_out(tua));
    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    function automatic logic [2:0] route_of(input logic [2:0] s, input logic fs, input logic cm);
        if (!s[2]) return 3'h0;
        if (s != 3'h4) return s - 3'h1;
        if (cm) return 3'h3;
        return fs ? 3'h2 : 3'h1;
    endfunction
    task automatic until_done(input logic ch, output int c);
        c = 0;
        do begin
            @(negedge sys_clk_in);
            c++;
        end while ((ch ? d2 : d1) !== 1'b1 && c < 100);
        if ((ch ? d2 : d1) !== 1'b1) begin
            failures++;
            $display("CHECK FAILED %0t no conversion result in time", $time);
        end
    endtask
    task automatic t_reset;
        chk(10'(tcode), 10'h002);
        chk(10'(tua), 10'h004);
        host.rd(8'h1B, got);
        chk(10'(got), 10'h002);
        chk(10'(r1), 10'h000);
    endtask
    task automatic t_trim;
        logic [5:0] codes [3] = '{6'h00, 6'h0A, 6'h3F};
        foreach (codes[i]) begin
            host.wr(8'h1B, {2'b00, codes[i]});
            repeat (3) @(negedge sys_clk_in);
            chk(10'(tcode), 10'(codes[i]));
            chk(10'(tua), 10'(codes[i]) * 10'h002);
        end
    endtask
    task automatic t_route;
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < 32; k++) begin
                host.wr(c ? 8'h15 : 8'h10, {k[4:2], 1'b0, k[0], 3'b000});
                host.wr(8'h1A, c ? {1'b0, k[1], 6'h00} : {5'h00, k[1], 2'b00});
                repeat (2) @(negedge sys_clk_in);
                chk(10'(c ? r2 : r1), 10'(route_of(k[4:2], k[1], k[0])));
            end
        end
    endtask
    task automatic t_convert;
        ch1_sample = 10'h2A5;
        ch2_sample = 10'h15A;
        host.wr(8'h10, 8'hE0);
        host.wr(8'h15, 8'hA0);
        host.rd(8'h10, got);
        chk(10'(got), 10'h0E0);
        host.rd(8'h1A, got);
        chk(10'(got), 10'h040);
        // settling scaled down with the conversion time
        repeat (2 * CONV) @(negedge sys_clk_in);
        until_done(1'b0, n);
        until_done(1'b0, n);
        chk(10'(n), 10'(CONV));
        until_done(1'b1, n);
        until_done(1'b1, n);
        chk(10'(n), 10'(CONV));
        host.rd_result(8'h03, v);
        chk(v, 10'h2A5);
        host.rd_result(8'h05, v);
        chk(v, 10'h15A);
        host.wr(8'h04, 8'h00);
        host.wr(8'h03, 8'h00);
        host.rd_result(8'h03, v);
        chk(v, 10'h2A5);
        until_done(1'b0, n);
        host.rd(8'h04, got);
        until_done(1'b0, n);
        chk(10'(n + 2), 10'(CONV));
        chk(10'(got), 10'h0A5);
        ch1_sample = 10'h3FF;
        until_done(1'b0, n);
        until_done(1'b0, n);
        host.rd_result(8'h03, v);
        chk(v, 10'h3FF);
    endtask
    task automatic t_standalone;
        host.rd(8'h1B, got);
        mode_pin = 1'b0;
        repeat (4) @(negedge sys_clk_in);
        chk(10'(mode), 10'h000);
        chk(10'(r1), 10'h000);
        host.wr(8'h1B, 8'h15);
        host.rd(8'h06, got);
        chk(10'(got), 10'h03F);
        chk(10'(tcode), 10'h03F);
        mode_pin = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        host.rd(8'h1B, got);
        chk(10'(got), 10'h03F);
    endtask
    initial begin
        repeat (10) @(negedge sys_clk_in);
        rst_in = 1'b0;
        repeat (4) @(negedge sys_clk_in);
        t_reset;
        t_trim;
        t_route;
        t_convert;
        t_standalone;
        wrap_up;
    end
    // the sequence needs about 600 cycles; the 10000-cycle limit allows over fifteen times that
    initial begin
        #50000;
        failures++;
        wrap_up;
    end
endmodule // dasc_top_test
`default_nettype wire
